/* logic/sweep_and_modulator_config_regs.sv */
// wishbone register bank holding sweep parameters and modulator configuration
// Functional notes
// - step size is 30-bit upper plus 18-bit lower; symmetric mode uses it both ways
// - asymmetric mode applies the up step size to the upward ramp only
// - step count is 30-bit upper plus 18-bit lower; symmetric uses it both ways
// - asymmetric mode uses the up step count for the upward ramp only
// - separate 48-bit down step size drives downward ramps in asymmetric mode only
// - bits 1:0 pick first accumulator width 48/32/24/16, reset 00
// - bits 3:2 pick second accumulator width, same encoding, reset 00
// - bits 5:4 pick third accumulator width, same encoding, reset 00
// - bits 8:6 stop fractional accumulator clocks, one each, reset 000
// - bits 11:9 stop integer accumulator clocks, one each, reset 000
// - bit 12 stops first modulator variant clock, reset running
// - bit 13 stops second modulator variant clock, reset running
// - bit 15 stops integer path clock, reset running
// - bit 16 stops input buffer clock, reset running
// - bit 17 stops output buffer clock, reset running
// - nothing decoded at address 17h
// - dwell time 30 upper plus 18 lower; both ways symmetric, up only asymmetric
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

module sweep_and_modulator_config_regs
    import sweep_cfg_pkg::*;
#(
    parameter int ADR_W = 8
)(
    // clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // wishbone classic slave
    input  wire logic                          cyc_i,
    input  wire logic                          stb_i,
    input  wire logic                          we_i,
    input  wire logic [ADR_W-1:0]              adr_i,
    input  wire logic [3:0]                    sel_i,
    input  wire logic [31:0]                   dat_i,
    output logic      [31:0]                   dat_o,
    output logic                               ack_o,
    // configuration toward sweep engine and modulator
    output var sweep_cfg_pkg::sweep_params_s   sweep_o,
    output var sweep_cfg_pkg::modulator_ctrl_s mod_ctrl_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // decode of a two-bit accumulator size field
    function automatic logic [5:0] acc_width(input logic [1:0] code);
        logic [5:0] w;
        unique case (code)
            ACC_SEL_48: w = ACC_W_48;
            ACC_SEL_32: w = ACC_W_32;
            ACC_SEL_24: w = ACC_W_24;
            default:    w = ACC_W_16;
        endcase
        return w;
    endfunction : acc_width

    ////////////////////////////////////////////////////////////////////////////////
    // bus decode
    //
    // word index map, byte address is four times the index:
    //   10 dwell up upper      11 dwell up lower
    //   12 step up upper       13 step up lower
    //   14 count up upper      15 count up lower
    //   16 modulator config    17 hole, nothing kept
    //   19 step down upper     1a step down lower
    //   30 sweep direction     31 width status, read only
    // every index answers, so a stray access never hangs the bus;
    // unmapped ones read zero and swallow writes.
    // timing: ack one cycle after the request is seen, for one cycle;
    // a request still standing while ack is high sees ack drop, then is answered again one cycle later.

    logic [5:0]  idx;
    logic        req;
    logic        wr_en;
    logic        ack_q;
    logic [31:0] rdata_d;
    logic [31:0] dat_q;

    assign idx   = adr_i[7:2];
    assign req   = cyc_i && stb_i;
    // write lands on the edge where the master sees ack, not before
    assign wr_en = req && we_i && ack_q;
    assign ack_o = ack_q;
    assign dat_o = dat_q;

    // one wait state, then ack for exactly one cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_q <= 1'b0;
        else
            ack_q <= req && !ack_q;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // storage

    logic [29:0]         dwell_up_hi_q, step_up_hi_q, count_up_hi_q, step_dn_hi_q;
    logic [17:0]         dwell_up_lo_q, step_up_lo_q, count_up_lo_q, step_dn_lo_q;
    logic [19:0]         modcfg_q;
    sweep_mode_e         mode_q;

    logic [31:0]         wmask;
    logic [29:0]         hi_msk;
    logic [29:0]         hi_dat;
    logic [17:0]         lo_msk;
    logic [17:0]         lo_dat;
    logic [19:0]         cfg_msk;
    logic [19:0]         cfg_dat;
    logic                wr_dwell_hi;
    logic                wr_dwell_lo;
    logic                wr_step_hi;
    logic                wr_step_lo;
    logic                wr_count_hi;
    logic                wr_count_lo;
    logic                wr_dn_hi;
    logic                wr_dn_lo;
    logic                wr_cfg;

    // byte-lane mask; a cleared sel bit keeps that byte of the register
    always_comb
    begin
        wmask = 32'h0;
        for (int b = 0; b < 4; b++)
        begin
            wmask[b*8 +: 8] = {8{sel_i[b]}};
        end
    end

    // bits above a register's width are dropped on purpose
    assign hi_msk  = wmask[UPPER_W-1:0];
    assign hi_dat  = dat_i[UPPER_W-1:0];
    assign lo_msk  = wmask[LOWER_W-1:0];
    assign lo_dat  = dat_i[LOWER_W-1:0];
    assign cfg_msk = wmask[MODCFG_W-1:0];
    assign cfg_dat = dat_i[MODCFG_W-1:0];

    // one write strobe per register, all gated by the acked write
    assign wr_dwell_hi = wr_en && (idx == IDX_DWELL_UP_UPPER);
    assign wr_dwell_lo = wr_en && (idx == IDX_DWELL_UP_LOWER);
    assign wr_step_hi  = wr_en && (idx == IDX_STEP_UP_UPPER);
    assign wr_step_lo  = wr_en && (idx == IDX_STEP_UP_LOWER);
    assign wr_count_hi = wr_en && (idx == IDX_COUNT_UP_UPPER);
    assign wr_count_lo = wr_en && (idx == IDX_COUNT_UP_LOWER);
    assign wr_dn_hi    = wr_en && (idx == IDX_STEP_DN_UPPER);
    assign wr_dn_lo    = wr_en && (idx == IDX_STEP_DN_LOWER);
    assign wr_cfg      = wr_en && (idx == IDX_MOD_CONFIG);

    // dwell upper half; halves update separately, no atomic pairing
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dwell_up_hi_q <= UPPER_RST;
        end
        else if (wr_dwell_hi)
        begin
            dwell_up_hi_q <= (dwell_up_hi_q & ~hi_msk) | (hi_dat & hi_msk);
        end
    end

    // dwell lower half
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dwell_up_lo_q <= LOWER_RST;
        end
        else if (wr_dwell_lo)
        begin
            dwell_up_lo_q <= (dwell_up_lo_q & ~lo_msk) | (lo_dat & lo_msk);
        end
    end

    // up step upper half
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            step_up_hi_q <= UPPER_RST;
        end
        else if (wr_step_hi)
        begin
            step_up_hi_q <= (step_up_hi_q & ~hi_msk) | (hi_dat & hi_msk);
        end
    end

    // up step lower half
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            step_up_lo_q <= LOWER_RST;
        end
        else if (wr_step_lo)
        begin
            step_up_lo_q <= (step_up_lo_q & ~lo_msk) | (lo_dat & lo_msk);
        end
    end

    // step count upper half
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            count_up_hi_q <= UPPER_RST;
        end
        else if (wr_count_hi)
        begin
            count_up_hi_q <= (count_up_hi_q & ~hi_msk) | (hi_dat & hi_msk);
        end
    end

    // step count lower half
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            count_up_lo_q <= LOWER_RST;
        end
        else if (wr_count_lo)
        begin
            count_up_lo_q <= (count_up_lo_q & ~lo_msk) | (lo_dat & lo_msk);
        end
    end

    // down step upper half
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            step_dn_hi_q <= UPPER_RST;
        end
        else if (wr_dn_hi)
        begin
            step_dn_hi_q <= (step_dn_hi_q & ~hi_msk) | (hi_dat & hi_msk);
        end
    end

    // down step lower half
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            step_dn_lo_q <= LOWER_RST;
        end
        else if (wr_dn_lo)
        begin
            step_dn_lo_q <= (step_dn_lo_q & ~lo_msk) | (lo_dat & lo_msk);
        end
    end

    // modulator config word; reserved bits are stored but steer nothing
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            modcfg_q <= MODCFG_RST;
        end
        else if (wr_cfg)
        begin
            modcfg_q <= (modcfg_q & ~cfg_msk) | (cfg_dat & cfg_msk);
        end
    end

    // sweep direction mode
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            mode_q <= SWEEP_SYMMETRIC;
        else if (wr_en && idx == IDX_SWEEP_CTRL && sel_i[0])
            mode_q <= dat_i[ASYM_BIT] ? SWEEP_ASYMMETRIC : SWEEP_SYMMETRIC;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read path

    modulator_ctrl_s mod_d;
    sweep_params_s   sweep_d;
    logic            asym;

    assign asym = (mode_q == SWEEP_ASYMMETRIC);

    // unmapped indices, the hole at 17h among them, read zero and ack
    always_comb
    begin
        rdata_d = 32'h0;
        unique case (idx)
            IDX_DWELL_UP_UPPER: rdata_d = {2'h0, dwell_up_hi_q};
            IDX_DWELL_UP_LOWER: rdata_d = {14'h0, dwell_up_lo_q};
            IDX_STEP_UP_UPPER:  rdata_d = {2'h0, step_up_hi_q};
            IDX_STEP_UP_LOWER:  rdata_d = {14'h0, step_up_lo_q};
            IDX_COUNT_UP_UPPER: rdata_d = {2'h0, count_up_hi_q};
            IDX_COUNT_UP_LOWER: rdata_d = {14'h0, count_up_lo_q};
            IDX_MOD_CONFIG:     rdata_d = {12'h0, modcfg_q};
            IDX_HOLE:           rdata_d = 32'h0;
            IDX_STEP_DN_UPPER:  rdata_d = {2'h0, step_dn_hi_q};
            IDX_STEP_DN_LOWER:  rdata_d = {14'h0, step_dn_lo_q};
            IDX_SWEEP_CTRL:     rdata_d = {31'h0, asym};
            IDX_STATUS:         rdata_d = {13'h0, mod_ctrl_o.acc3_width,
                                           mod_ctrl_o.acc2_width,
                                           mod_ctrl_o.acc1_width, sweep_o.asymmetric};
            default:            rdata_d = 32'h0;
        endcase
    end

    // read data captured as ack rises and held while it stands
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_q <= 32'h0;
        else if (req && !ack_q && !we_i)
            dat_q <= rdata_d;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // effective configuration

    // down-direction count and dwell live outside this bank in asymmetric mode
    always_comb
    begin
        sweep_d.asymmetric = asym;
        sweep_d.up_step    = {step_up_hi_q, step_up_lo_q};
        sweep_d.up_count   = {count_up_hi_q, count_up_lo_q};
        sweep_d.up_dwell   = {dwell_up_hi_q, dwell_up_lo_q};
        // symmetric reuses the up step; asymmetric takes the down register
        sweep_d.down_step  = asym ? {step_dn_hi_q, step_dn_lo_q}
                                  : {step_up_hi_q, step_up_lo_q};
        sweep_d.down_count = asym ? 48'h0 : {count_up_hi_q, count_up_lo_q};
        sweep_d.down_dwell = asym ? 48'h0 : {dwell_up_hi_q, dwell_up_lo_q};
    end

    // a set bit stops the clock, so enables are the inverse
    always_comb
    begin
        mod_d.acc1_width      = acc_width(modcfg_q[ACC1_LSB +: 2]);
        mod_d.acc2_width      = acc_width(modcfg_q[ACC2_LSB +: 2]);
        mod_d.acc3_width      = acc_width(modcfg_q[ACC3_LSB +: 2]);
        mod_d.frac_clk_en     = ~modcfg_q[FRAC_GATE_LSB +: 3];
        mod_d.int_clk_en      = ~modcfg_q[INT_GATE_LSB +: 3];
        mod_d.mode_a_clk_en   = ~modcfg_q[MODE_A_BIT];
        mod_d.mode_b_clk_en   = ~modcfg_q[MODE_B_BIT];
        mod_d.int_path_clk_en = ~modcfg_q[INT_PATH_BIT];
        mod_d.in_buf_clk_en   = ~modcfg_q[IN_BUF_BIT];
        mod_d.out_buf_clk_en  = ~modcfg_q[OUT_BUF_BIT];
    end

    // outputs registered so the datapath sees glitch-free controls
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sweep_o    <= '0;
            mod_ctrl_o <= {ACC_W_48, ACC_W_48, ACC_W_48, 3'h7, 3'h7, 5'h1f};
        end
        else
        begin
            sweep_o    <= sweep_d;
            mod_ctrl_o <= mod_d;
        end
    end

endmodule : sweep_and_modulator_config_regs

`default_nettype wire

/* logic/sweep_cfg_pkg.sv */
// constants, register map and carrier types for the sweep and modulator config bank
package sweep_cfg_pkg;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_DWELL_UP_UPPER = 6'h10;
    localparam logic [5:0] IDX_DWELL_UP_LOWER = 6'h11;
    localparam logic [5:0] IDX_STEP_UP_UPPER  = 6'h12;
    localparam logic [5:0] IDX_STEP_UP_LOWER  = 6'h13;
    localparam logic [5:0] IDX_COUNT_UP_UPPER = 6'h14;
    localparam logic [5:0] IDX_COUNT_UP_LOWER = 6'h15;
    localparam logic [5:0] IDX_MOD_CONFIG     = 6'h16;
    localparam logic [5:0] IDX_HOLE           = 6'h17;
    localparam logic [5:0] IDX_STEP_DN_UPPER  = 6'h19;
    localparam logic [5:0] IDX_STEP_DN_LOWER  = 6'h1a;
    localparam logic [5:0] IDX_SWEEP_CTRL     = 6'h30;
    localparam logic [5:0] IDX_STATUS         = 6'h31;

    // field widths
    localparam int UPPER_W = 30;
    localparam int LOWER_W = 18;
    localparam int PARAM_W = 48;
    localparam int MODCFG_W = 20;

    // reset values
    localparam logic [29:0] UPPER_RST  = 30'h0;
    localparam logic [17:0] LOWER_RST  = 18'h0;
    localparam logic [19:0] MODCFG_RST = 20'h0;

    // modulator config field positions
    localparam int ACC1_LSB     = 0;
    localparam int ACC2_LSB     = 2;
    localparam int ACC3_LSB     = 4;
    localparam int FRAC_GATE_LSB = 6;
    localparam int INT_GATE_LSB = 9;
    localparam int MODE_A_BIT   = 12;
    localparam int MODE_B_BIT   = 13;
    localparam int INT_PATH_BIT = 15;
    localparam int IN_BUF_BIT   = 16;
    localparam int OUT_BUF_BIT  = 17;

    // accumulator width encodings and the widths they give
    localparam logic [1:0] ACC_SEL_48 = 2'h0;
    localparam logic [1:0] ACC_SEL_32 = 2'h1;
    localparam logic [1:0] ACC_SEL_24 = 2'h2;
    localparam logic [5:0] ACC_W_48 = 6'h30;
    localparam logic [5:0] ACC_W_32 = 6'h20;
    localparam logic [5:0] ACC_W_24 = 6'h18;
    localparam logic [5:0] ACC_W_16 = 6'h10;

    // sweep control bit and status field positions
    localparam int ASYM_BIT      = 0;
    localparam int STAT_W1_LSB   = 1;
    localparam int STAT_W2_LSB   = 7;
    localparam int STAT_W3_LSB   = 13;

    typedef enum logic {SWEEP_SYMMETRIC, SWEEP_ASYMMETRIC} sweep_mode_e;

    // effective sweep parameters seen by the sweep engine
    typedef struct packed {
        logic [47:0] up_step;
        logic [47:0] down_step;
        logic [47:0] up_count;
        logic [47:0] down_count;
        logic [47:0] up_dwell;
        logic [47:0] down_dwell;
        logic        asymmetric;
    } sweep_params_s;

    // modulator configuration seen by the datapath; enables are active high
    typedef struct packed {
        logic [5:0] acc1_width;
        logic [5:0] acc2_width;
        logic [5:0] acc3_width;
        logic [2:0] frac_clk_en;
        logic [2:0] int_clk_en;
        logic       mode_a_clk_en;
        logic       mode_b_clk_en;
        logic       int_path_clk_en;
        logic       in_buf_clk_en;
        logic       out_buf_clk_en;
    } modulator_ctrl_s;

endpackage : sweep_cfg_pkg

/* testbench/sweep_cfg_properties.sv */
// concurrent checks on the ports of the sweep and modulator config bank
`timescale 1ns/1ps
`default_nettype none

module sweep_cfg_properties
    import sweep_cfg_pkg::*;
#(
    parameter int ADR_W = 8
)(
    // clock, reset and bus
    input wire logic                           clk_i,
    input wire logic                           rst_i,
    input wire logic                           cyc_i,
    input wire logic                           stb_i,
    input wire logic                           we_i,
    input wire logic [ADR_W-1:0]               adr_i,
    input wire logic [3:0]                     sel_i,
    input wire logic [31:0]                    dat_i,
    input wire logic [31:0]                    dat_o,
    input wire logic                           ack_o,
    // configuration outputs
    input wire sweep_cfg_pkg::sweep_params_s   sweep_o,
    input wire sweep_cfg_pkg::modulator_ctrl_s mod_ctrl_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // width code to width; kept here so the design's own decode is not reused
    function automatic logic [5:0] acc_w(input logic [1:0] c);
        return (c == 2'h0) ? 6'h30 : (c == 2'h1) ? 6'h20 : (c == 2'h2) ? 6'h18 : 6'h10;
    endfunction : acc_w

    ////////////////////////////////////////////////////////////////////////////
    // full-word write accepted at one register; outputs follow two edges later
    sequence s_wr(logic [5:0] idx);
        cyc_i && stb_i && we_i && ack_o && sel_i == 4'hf && adr_i[7:2] == idx;
    endsequence
    property p_ack;
        cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
    endproperty
    property p_acc1;
        s_wr(IDX_MOD_CONFIG) |-> ##2 mod_ctrl_o.acc1_width == acc_w($past(dat_i[1:0], 2));
    endproperty
    property p_acc23;
        s_wr(IDX_MOD_CONFIG) |-> ##2 {mod_ctrl_o.acc2_width, mod_ctrl_o.acc3_width}
            == {acc_w($past(dat_i[3:2], 2)), acc_w($past(dat_i[5:4], 2))};
    endproperty
    property p_gate;
        s_wr(IDX_MOD_CONFIG) |-> ##2 {mod_ctrl_o.int_clk_en, mod_ctrl_o.frac_clk_en}
            == ~$past(dat_i[11:6], 2);
    endproperty
    property p_stage;
        s_wr(IDX_MOD_CONFIG) |-> ##2 {mod_ctrl_o.out_buf_clk_en, mod_ctrl_o.in_buf_clk_en,
            mod_ctrl_o.int_path_clk_en, mod_ctrl_o.mode_b_clk_en, mod_ctrl_o.mode_a_clk_en}
            == ~{$past(dat_i[17:15], 2), $past(dat_i[13:12], 2)};
    endproperty
    property p_step;
        s_wr(IDX_STEP_UP_UPPER) |-> ##2 sweep_o.up_step[47:18] == $past(dat_i[29:0], 2);
    endproperty
    property p_sym;
        !sweep_o.asymmetric |-> sweep_o.down_step == sweep_o.up_step
            && sweep_o.down_count == sweep_o.up_count;
    endproperty
    property p_hole;
        ack_o && !we_i && adr_i[7:2] == IDX_HOLE |-> dat_o == 32'h0;
    endproperty

    ////////////////////////////////////////////////////////////////////////////
    a_ack: assert property (p_ack) else $error("bus answer not a single pulse");
    a_acc1: assert property (p_acc1) else $error("first width wrong");
    a_acc23: assert property (p_acc23) else $error("second or third width wrong");
    a_gate: assert property (p_gate) else $error("accumulator gates wrong");
    a_stage: assert property (p_stage) else $error("stage gates wrong");
    a_step: assert property (p_step) else $error("upper step misplaced");
    a_sym: assert property (p_sym) else $error("symmetric copy wrong");
    a_hole: assert property (p_hole) else $error("hole reads nonzero");

endmodule : sweep_cfg_properties

bind sweep_and_modulator_config_regs sweep_cfg_properties #(.ADR_W(ADR_W)) u_props (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sweep_o(sweep_o),
    .mod_ctrl_o(mod_ctrl_o));
`default_nettype wire

/* testbench/sweep_and_modulator_config_regs_tb.sv */
// self-checking bench for the sweep and modulator config register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end

module sweep_and_modulator_config_regs_tb
    import sweep_cfg_pkg::*;
;
    // bus, outputs and bookkeeping
    logic            clk_i = 1'b0;
    logic            rst_i = 1'b1;
    logic            cyc_i = 1'b0;
    logic            stb_i = 1'b0;
    logic            we_i  = 1'b0;
    logic [7:0]      adr_i = 8'h0;
    logic [3:0]      sel_i = 4'h0;
    logic [31:0]     dat_i = 32'h0;
    logic [31:0]     dat_o;
    logic            ack_o;
    sweep_params_s   sweep_o;
    modulator_ctrl_s mod_ctrl_o;
    int              err_total = 0;
    int              checked = 0;
    logic [31:0]     rd;
    logic [19:0]     v;
    logic [28:0]     e;
    logic [5:0]      idx_t [10] = '{6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17,
                                    6'h19, 6'h1a};
    logic [31:0]     msk_t [10] = '{32'h3fffffff, 32'h3ffff, 32'h3fffffff, 32'h3ffff,
                                    32'h3fffffff, 32'h3ffff, 32'hfffff, 32'h0,
                                    32'h3fffffff, 32'h3ffff};
    logic [31:0]     par_t [8] = '{32'h2345abcd, 32'h1b2c3, 32'h1a2b3c4d, 32'h25e6f,
                                   32'h3456789a, 32'h3c0de, 32'h0badf00d, 32'h12345};
    logic [19:0]     gate_t [4] = '{20'h0, 20'h3bfc0, 20'h12a40, 20'h29580};
    logic [5:0]      w_t [4] = '{ACC_W_48, ACC_W_32, ACC_W_24, ACC_W_16};
    logic [47:0]     es = {30'h2345abcd, 18'h1b2c3};
    logic [47:0]     ec = {30'h1a2b3c4d, 18'h25e6f};
    logic [47:0]     ed = {30'h3456789a, 18'h3c0de};
    logic [47:0]     ew = {30'h0badf00d, 18'h12345};

    // 50 ns clock
    always #25 clk_i = ~clk_i;

    sweep_and_modulator_config_regs #(.ADR_W(8)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .sweep_o(sweep_o), .mod_ctrl_o(mod_ctrl_o));

    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    // one classic cycle; returns a cycle after the drop so outputs have landed
    task automatic wb(input logic w, input logic [5:0] idx, input logic [31:0] d,
                      input logic [3:0] s);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= {idx, 2'h0};
        sel_i <= s;
        dat_i <= d;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            err_total++;
            summarize();
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        @(posedge clk_i);
        #1;
    endtask : wb

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        `CHK("sweep reset", 289'h0, sweep_o)
        `CHK("mod reset", {ACC_W_48, ACC_W_48, ACC_W_48, 11'h7ff}, mod_ctrl_o)
        // reset value, then width of each register from 10h to 1ah; the hole keeps nothing
        foreach (idx_t[i])
        begin
            wb(1'b0, idx_t[i], 32'h0, 4'hf);
            `CHK("reset value", 32'h0, rd)
            wb(1'b1, idx_t[i], 32'hffffffff, 4'hf);
            wb(1'b0, idx_t[i], 32'h0, 4'hf);
            `CHK("readback", msk_t[i], rd)
        end
        // every width code in every field, with varied gate patterns
        for (int i = 0; i < 4; i++)
        begin
            v = gate_t[i] | 20'(i) | 20'(i) << 2 | 20'(3 - i) << 4;
            wb(1'b1, IDX_MOD_CONFIG, {12'h0, v}, 4'hf);
            e = {w_t[i], w_t[i], w_t[3 - i], ~v[8:6], ~v[11:9], ~v[12], ~v[13], ~v[15],
                 ~v[16], ~v[17]};
            `CHK("mod ctrl", e, mod_ctrl_o)
        end
        // reserved bits are kept but change nothing downstream
        wb(1'b1, IDX_MOD_CONFIG, 32'hc4000, 4'hf);
        `CHK("reserved", {ACC_W_48, ACC_W_48, ACC_W_48, 11'h7ff}, mod_ctrl_o)
        // sweep parameters, symmetric then asymmetric then back
        for (int i = 0; i < 8; i++)
            wb(1'b1, idx_t[(i < 4) ? i + 2 : (i < 6) ? i + 4 : i - 6], par_t[i], 4'hf);
        `CHK("up step", es, sweep_o.up_step)
        `CHK("sym down step", es, sweep_o.down_step)
        `CHK("sym down count", ec, sweep_o.down_count)
        `CHK("sym down dwell", ew, sweep_o.down_dwell)
        wb(1'b1, IDX_SWEEP_CTRL, 32'h1, 4'h1);
        `CHK("asym up step", es, sweep_o.up_step)
        `CHK("asym down step", ed, sweep_o.down_step)
        `CHK("asym up count", ec, sweep_o.up_count)
        `CHK("asym down count", 48'h0, sweep_o.down_count)
        `CHK("asym up dwell", ew, sweep_o.up_dwell)
        wb(1'b1, IDX_SWEEP_CTRL, 32'h0, 4'h1);
        `CHK("back to sym", es, sweep_o.down_step)
        summarize();
    end

endmodule : sweep_and_modulator_config_regs_tb
`default_nettype wire
